// file: pkg/upc_pkg.sv
// upc_pkg: register map, control field positions, reset value and timing constants
// assumes a single 100 MHz clock and the plain register port of upc_top
package upc_pkg;
    localparam int unsigned UPC_ADDR_W = 8;
    localparam logic [7:0] UPC_OFS_CTRL = 8'h30;     // port_control
    localparam logic [7:0] UPC_OFS_STATUS = 8'h34;   // activity status
    localparam logic [7:0] UPC_OFS_DATA = 8'h38;     // transmit / receive character
    localparam logic [7:0] UPC_OFS_BAUD = 8'h3C;     // 16x baud divisor
    localparam int unsigned UPC_EN_BIT = 0;
    localparam int unsigned UPC_SIR_BIT = 1;
    localparam int unsigned UPC_INFRARED_LOW_POWER_SELECT_BIT = 2;
    localparam int unsigned UPC_LBE_BIT = 7;
    localparam int unsigned UPC_TXE_BIT = 8;
    localparam int unsigned UPC_RXE_BIT = 9;
    localparam logic [31:0] UPC_CTRL_RESET = 32'h0000_0300;
    localparam logic [31:0] UPC_CTRL_MASK = 32'h0000_0387;  // writable bits
    localparam logic [15:0] UPC_BAUD_RESET = 16'h0036;      // about 115200 baud x16
    localparam int unsigned UPC_OS = 16;        // ticks per bit
    localparam int unsigned UPC_SIR_TICKS = 3;  // 3/16 pulse, in 16x ticks
    localparam int unsigned UPC_LP_TICKS = 3;   // low-power pulse, in ref periods
    localparam int unsigned UPC_LP_REF_NS = 600;  // low-power reference period
    localparam int unsigned UPC_CLK_NS = 10;
    localparam int unsigned UPC_LP_REF_CYC = UPC_LP_REF_NS / UPC_CLK_NS;
    localparam int unsigned UPC_FRAME_BITS = 10;  // start, 8 data, stop
endpackage

// file: rtl/upc_top.sv
// upc_top: control portion of an asynchronous serial port with infrared option
// assumes one clock ref_clk, synchronous reset, a master on the plain register port
// What this block does
// R1: transmitter starts a character only while transmit enable and global enable are both one.
// R2: clearing transmit enable mid-character finishes that character first.
// R3: loopback routes the transmit output internally into the receive path.
// R4: infrared normal mode sends each zero bit as a 3/16 bit high pulse.
// R5: low-power mode pulse lasts three low-power reference periods at baud divisors of 11 and up, where it fits inside a zero bit.
// R6: infrared enable makes transmit and receive use infrared encoding.
// R7: global enable gates the whole port.
// R8: clearing global enable mid-character finishes the character in either direction.
// R9: software preserves control bits 6 to 3 and ignores their value.
// R10: receiver runs only with receive and global enable; finishes a started character.
// R11: control register resets to 0x0000_0300.
// R12: in infrared mode a one bit leaves the output low.
`timescale 1ns/1ps
`default_nettype none
module upc_top (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic [upc_pkg::UPC_ADDR_W-1:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    input wire logic serial_receive_in,
    output logic serial_transmit_out
);
    import upc_pkg::*;

    typedef enum logic [2:0] {
        UPC_IDLE = 3'b001,
        UPC_SHIFT = 3'b010,
        UPC_DONE = 3'b100
    } upc_phase_t;

    typedef struct packed {
        logic [31:0] port_control;
        logic [15:0] baud_div;
        logic [31:0] rdata;
        logic [2:0] rx_sync;
        logic rx_line;
        logic [15:0] div_cnt;
        logic [7:0] lp_cnt;
        logic lp_tick;
        logic [1:0] lp_pulse;
        upc_phase_t tx_ph;
        logic [3:0] tx_tick;
        logic [3:0] tx_bit;
        logic [9:0] tx_sh;
        logic [7:0] tx_buf;
        logic tx_pend;
        logic tx_out;
        upc_phase_t rx_ph;
        logic [3:0] rx_tick;
        logic [3:0] rx_bit;
        logic [7:0] rx_sh;
        logic [7:0] rx_data;
        logic rx_avail;
        logic [3:0] rx_pw;
    } upc_state_t;

    upc_state_t s;
    upc_state_t next_s;

    logic en, tx_en, rx_en, sir, infrared_low_power_select, loopback_enable, tick;
    logic line_in, rx_bitval, rx_low;

    // decoded enables
    assign en = s.port_control[UPC_EN_BIT];                 // see R7
    assign tx_en = en && s.port_control[UPC_TXE_BIT];       // see R1
    assign rx_en = en && s.port_control[UPC_RXE_BIT];       // see R10
    assign sir = s.port_control[UPC_SIR_BIT];
    assign infrared_low_power_select = s.port_control[UPC_INFRARED_LOW_POWER_SELECT_BIT];
    assign loopback_enable = s.port_control[UPC_LBE_BIT];
    assign tick = (s.div_cnt == 16'h0000);

    // receive source: loopback takes the internal transmit signal
    assign line_in = loopback_enable ? s.tx_out : s.rx_line;            // see R3
    // infrared receive: a high pulse marks a zero bit; plain line is level
    assign rx_low = sir ? line_in : !line_in;               // see R6
    assign rx_bitval = sir ? (s.rx_pw == 4'h0) : line_in;

    assign rdata = s.rdata;
    assign serial_transmit_out = loopback_enable ? (sir ? 1'b0 : 1'b1) : s.tx_out;

    // next-state logic
    always_comb begin
        next_s = s;
        next_s.rdata = 32'h0000_0000;
        // three-stage pin synchroniser; change accepted once stages two and three agree
        next_s.rx_sync = {s.rx_sync[1:0], serial_receive_in};
        if (s.rx_sync[2] == s.rx_sync[1]) begin
            next_s.rx_line = s.rx_sync[2];
        end
        // 16x baud enable
        next_s.div_cnt = tick ? s.baud_div : s.div_cnt - 16'h0001;
        // low-power reference divider
        // enable stands in the cycle in which the count is zero
        next_s.lp_tick = (s.lp_cnt == 8'h01);
        next_s.lp_cnt = (s.lp_cnt == 8'h00) ? 8'(UPC_LP_REF_CYC - 1) : s.lp_cnt - 8'h01;
        if (s.lp_tick && s.lp_pulse != 2'b00) begin
            next_s.lp_pulse = s.lp_pulse - 2'b01;
        end

        // register writes; bits 6:3 and 31:10 stay zero
        if (wr) begin
            unique case (addr)
                UPC_OFS_CTRL: next_s.port_control = wdata & UPC_CTRL_MASK;  // see R9
                UPC_OFS_BAUD: next_s.baud_div = wdata[15:0];
                UPC_OFS_DATA: begin
                    next_s.tx_buf = wdata[7:0];
                    next_s.tx_pend = 1'b1;
                end
                default: ;
            endcase
        end
        // register reads, data one cycle later; unmapped reads zero
        if (rd) begin
            unique case (addr)
                UPC_OFS_CTRL: next_s.rdata = s.port_control;
                UPC_OFS_BAUD: next_s.rdata = {16'h0000, s.baud_div};
                UPC_OFS_STATUS: next_s.rdata = {28'h0000_000, s.rx_avail, s.tx_pend,
                                                s.rx_ph != UPC_IDLE, s.tx_ph != UPC_IDLE};
                UPC_OFS_DATA: begin
                    next_s.rdata = {24'h00_0000, s.rx_data};
                    next_s.rx_avail = 1'b0;
                end
                default: ;
            endcase
        end

        // transmitter: starts only when enabled, once started finishes the frame
        unique case (s.tx_ph)
            UPC_IDLE: begin
                next_s.tx_out = !sir;                       // see R12
                if (tx_en && s.tx_pend && tick) begin       // see R1
                    next_s.tx_sh = {1'b1, s.tx_buf, 1'b0};
                    next_s.tx_pend = wr && addr == UPC_OFS_DATA;
                    next_s.tx_tick = 4'h0;
                    next_s.tx_bit = 4'h0;
                    next_s.tx_ph = UPC_SHIFT;
                end
            end
            UPC_SHIFT: begin
                // enables are not checked here so a started character completes
                if (tick) begin                             // see R2, R8
                    if (s.tx_tick == 4'(UPC_OS - 1)) begin
                        next_s.tx_tick = 4'h0;
                        next_s.tx_sh = {1'b1, s.tx_sh[9:1]};
                        next_s.tx_bit = s.tx_bit + 4'h1;
                        if (s.tx_bit == 4'(UPC_FRAME_BITS - 1)) begin
                            next_s.tx_ph = UPC_DONE;
                        end
                    end else begin
                        next_s.tx_tick = s.tx_tick + 4'h1;
                    end
                    if (s.tx_tick == 4'h0 && !s.tx_sh[0]) begin
                        next_s.lp_pulse = 2'(UPC_LP_TICKS);
                        // restart the reference so the pulse spans whole periods only
                        next_s.lp_cnt = 8'(UPC_LP_REF_CYC - 1);  // see R5
                        next_s.lp_tick = 1'b0;
                    end
                end
                if (!sir) begin
                    next_s.tx_out = s.tx_sh[0];
                end else if (infrared_low_power_select) begin
                    // pulse counted in low-power reference periods
                    next_s.tx_out = !s.tx_sh[0] && s.lp_pulse != 2'b00;  // see R5
                end else begin
                    // high for the first three of sixteen ticks of a zero bit
                    next_s.tx_out = !s.tx_sh[0] && s.tx_tick < 4'(UPC_SIR_TICKS);  // see R4, R6
                end
            end
            UPC_DONE: begin
                next_s.tx_out = !sir;
                next_s.tx_ph = UPC_IDLE;
            end
            default: next_s.tx_ph = UPC_IDLE;
        endcase

        // infrared receive pulse stretcher: holds a zero for the rest of the bit
        if (tick) begin
            if (sir && line_in) begin
                next_s.rx_pw = 4'(UPC_OS - 1);
            end else if (s.rx_pw != 4'h0) begin
                next_s.rx_pw = s.rx_pw - 4'h1;
            end
        end

        // receiver: start only while enabled, a started character completes
        unique case (s.rx_ph)
            UPC_IDLE: begin
                if (rx_en && tick && rx_low) begin          // see R10
                    next_s.rx_tick = 4'h0;
                    next_s.rx_bit = 4'h0;
                    next_s.rx_ph = UPC_SHIFT;
                end
            end
            UPC_SHIFT: begin
                if (tick) begin                             // see R8, R10
                    next_s.rx_tick = s.rx_tick + 4'h1;
                    if (s.rx_tick == 4'(UPC_OS / 2 - 1)) begin
                        next_s.rx_bit = s.rx_bit + 4'h1;
                        if (s.rx_bit == 4'h0 && rx_bitval) begin
                            next_s.rx_ph = UPC_IDLE;        // false start
                        end else if (s.rx_bit != 4'h0 &&
                                     s.rx_bit != 4'(UPC_FRAME_BITS - 1)) begin
                            next_s.rx_sh = {rx_bitval, s.rx_sh[7:1]};
                        end else if (s.rx_bit == 4'(UPC_FRAME_BITS - 1)) begin
                            next_s.rx_ph = UPC_DONE;
                        end
                    end
                end
            end
            UPC_DONE: begin
                next_s.rx_data = s.rx_sh;
                next_s.rx_avail = 1'b1;                     // set wins over read clear
                next_s.rx_ph = UPC_IDLE;
            end
            default: next_s.rx_ph = UPC_IDLE;
        endcase
    end

    // state register
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            s <= '0;
            s.port_control <= UPC_CTRL_RESET;               // see R11
            s.baud_div <= UPC_BAUD_RESET;
            s.rx_sync <= 3'b111;
            s.rx_line <= 1'b1;
            s.tx_out <= 1'b1;
            s.tx_ph <= UPC_IDLE;
            s.rx_ph <= UPC_IDLE;
        end else begin
            s <= next_s;
        end
    end
endmodule // upc_top
`default_nettype wire

// file: verif/upc_peer.sv
// upc_peer: remote serial port on the pins, plain line levels
// assumes a bit period of BIT clocks and a receive line with pull-up
`timescale 1ns/1ps
`default_nettype none
module upc_peer #(
    parameter int BIT = 256
) (
    input wire logic ref_clk,
    input wire logic line,
    output logic rx_line
);
    logic [9:0] f;
    // idle mark level until a frame is sent
    initial rx_line = 1'b1;
    // stop, data, start: sent lsb first, one bit period each
    task automatic send(input logic [7:0] b);
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            rx_line <= f[i];
            repeat (BIT) @(posedge ref_clk);
        end
    endtask
    // wait for a start edge, then sample each data bit in its middle
    task automatic recv(output logic [7:0] b);
        @(negedge line);
        repeat (BIT / 2) @(posedge ref_clk);
        for (int i = 0; i < 9; i++) begin
            repeat (BIT) @(posedge ref_clk);
            if (i < 8) b[i] = line;
        end
    endtask
endmodule // upc_peer
`default_nettype wire

// file: verif/upc_sva.sv
// upc_sva: assertions on the ports of upc_top, bound after the module
// assumes register writes are the only source of mode changes
`timescale 1ns/1ps
`default_nettype none
module upc_sva (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic [upc_pkg::UPC_ADDR_W-1:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [31:0] rdata,
    input wire logic serial_receive_in,
    input wire logic serial_transmit_out
);
    import upc_pkg::*;
    localparam int OFF_MAX = 9000;  // longest frame at any divisor in use
    logic [31:0] ctl;
    logic [15:0] baud;
    logic tx;
    int off_cnt, hi_cnt, ir_age;
    assign tx = serial_transmit_out;
    // shadow of control and divisor, run lengths seen on the output
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            ctl <= UPC_CTRL_RESET;
            baud <= UPC_BAUD_RESET;
            off_cnt <= 0;
            hi_cnt <= 0;
            ir_age <= 0;
        end else begin
            if (wr && addr == UPC_OFS_CTRL) ctl <= wdata & UPC_CTRL_MASK;
            if (wr && addr == UPC_OFS_BAUD) baud <= wdata[15:0];
            off_cnt <= (ctl[UPC_EN_BIT] && ctl[UPC_TXE_BIT]) ? 0 : off_cnt + 1;
            hi_cnt <= tx ? hi_cnt + 1 : 0;
            ir_age <= (!ctl[UPC_SIR_BIT] || (wr && addr == UPC_OFS_CTRL)) ? 0 : ir_age + 1;
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    sequence s_ctl_rd;
        rd && addr == UPC_OFS_CTRL;
    endsequence
    sequence s_ir_fall;
        $fell(tx) && ir_age > 8;
    endsequence
    a_rdata_quiet: assert property (!$past(rd) |-> rdata == 32'h0000_0000)
        else $error("read data not zero outside an answer");
    a_ctl_read: assert property (s_ctl_rd |=> rdata == $past(ctl))
        else $error("control read differs");
    a_ctl_reserved: assert property (s_ctl_rd |=> rdata[31:10] == 22'h00_0000 && rdata[6:3] == 4'h0)
        else $error("reserved control bits not zero");
    a_tx_gated: assert property (off_cnt > OFF_MAX && !ctl[UPC_SIR_BIT] |-> tx)
        else $error("transmit active while disabled");
    a_loop_idle: assert property (ctl[UPC_LBE_BIT] && !ctl[UPC_SIR_BIT] |-> tx)
        else $error("pin not idle in loopback");
    a_ir_width: assert property ((s_ir_fall and !ctl[UPC_INFRARED_LOW_POWER_SELECT_BIT])
        |-> hi_cnt == UPC_SIR_TICKS * (baud + 1))
        else $error("infrared pulse width wrong");
    a_lp_width: assert property ((s_ir_fall and ctl[UPC_INFRARED_LOW_POWER_SELECT_BIT])
        |-> hi_cnt == UPC_LP_TICKS * UPC_LP_REF_CYC)
        else $error("low power pulse width wrong");
    a_ir_one_low: assert property (ir_age > 8 && tx |-> hi_cnt < (ctl[UPC_INFRARED_LOW_POWER_SELECT_BIT] ? 180 : 3 * (baud + 1)))
        else $error("infrared output high too long");
endmodule // upc_sva
bind upc_top upc_sva upc_sva_i (.ref_clk(ref_clk), .resetn(resetn), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .serial_receive_in(serial_receive_in),
    .serial_transmit_out(serial_transmit_out));
`default_nettype wire

// file: verif/upc_top_tb.sv
// upc_top_tb: self-checking bench for the serial port control block
// assumes upc_peer on the pins and the register map of upc_pkg
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin mismatches++; \
    $display("wrong value %s expected %h seen %h", n, e, g); end end
module upc_top_tb;
    import upc_pkg::*;
    localparam int BIT = 256;  // divisor 15: 16 clocks a tick
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic [31:0] rdata;
    logic rx_line, tx;
    logic [7:0] v;
    int mismatches = 0;
    int comparisons = 0;
    int cycles = 0;
    always #5 ref_clk = ~ref_clk;
    upc_top upc_top_i (.ref_clk(ref_clk), .resetn(resetn), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .serial_receive_in(rx_line), .serial_transmit_out(tx));
    upc_peer #(.BIT(BIT)) upc_peer_i (.ref_clk(ref_clk), .line(tx), .rx_line(rx_line));
    // one write strobe, then a quiet cycle
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
        @(posedge ref_clk);
    endtask
    // one read strobe, answer judged in the following cycle
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1 `CHK("rdata", e, rdata)
    endtask
    // frame caught by the peer; data d written, control c after w cycles
    task automatic tx_chk(input logic [7:0] d, input logic [31:0] c, input int w);
        fork
            upc_peer_i.recv(v);
            begin
                wr_reg(UPC_OFS_DATA, {24'h00_0000, d});
                repeat (w) @(posedge ref_clk);
                if (w > 1000) #1 `CHK("idle line", 1'b1, tx)
                wr_reg(UPC_OFS_CTRL, c);
            end
        join
        `CHK("frame", d, v)
    endtask
    // reset value, reserved bits, unmapped read, short divisor
    task automatic t_regs;
        rd_chk(UPC_OFS_CTRL, UPC_CTRL_RESET);
        wr_reg(UPC_OFS_CTRL, 32'hFFFF_FFFF);
        rd_chk(UPC_OFS_CTRL, 32'h0000_0387);
        rd_chk(8'h00, 32'h0000_0000);
        wr_reg(UPC_OFS_BAUD, 32'h0000_000F);
    endtask
    // frame held back until both enables are set
    task automatic t_gate;
        wr_reg(UPC_OFS_CTRL, 32'h0000_0201);
        tx_chk(8'h00, 32'h0000_0301, 1500);
        wr_reg(UPC_OFS_CTRL, 32'h0000_0300);
        tx_chk(8'h00, 32'h0000_0301, 9100);
    endtask
    // enables cleared mid-frame: the frame still completes
    task automatic t_abort;
        wr_reg(UPC_OFS_CTRL, 32'h0000_0301);
        tx_chk(8'h96, 32'h0000_0300, 3 * BIT);
        wr_reg(UPC_OFS_CTRL, 32'h0000_0301);
        tx_chk(8'h69, 32'h0000_0201, 3 * BIT);
    endtask
    // loopback: own frame received while the pin stays idle, plain and infrared
    task automatic t_loop;
        wr_reg(UPC_OFS_CTRL, 32'h0000_0381);
        wr_reg(UPC_OFS_DATA, 32'h0000_003C);
        repeat (11 * BIT) @(posedge ref_clk);
        rd_chk(UPC_OFS_DATA, 32'h0000_003C);
        wr_reg(UPC_OFS_CTRL, 32'h0000_0382);
        wr_reg(UPC_OFS_DATA, 32'h0000_005A);
        repeat (BIT) @(posedge ref_clk);
        wr_reg(UPC_OFS_CTRL, 32'h0000_0383);
        repeat (11 * BIT) @(posedge ref_clk);
        rd_chk(UPC_OFS_DATA, 32'h0000_005A);
    endtask
    // receiver finishes when disabled mid-frame, ignores frames when off
    task automatic t_rx;
        wr_reg(UPC_OFS_CTRL, 32'h0000_0301);
        fork
            upc_peer_i.send(8'hA7);
            begin
                repeat (4 * BIT) @(posedge ref_clk);
                wr_reg(UPC_OFS_CTRL, 32'h0000_0300);
            end
        join
        repeat (BIT) @(posedge ref_clk);
        rd_chk(UPC_OFS_DATA, 32'h0000_00A7);
        wr_reg(UPC_OFS_CTRL, 32'h0000_0101);
        upc_peer_i.send(8'h11);
        rd_chk(UPC_OFS_STATUS, 32'h0000_0000);
    endtask
    // infrared: pulse width per mode, one pulse per zero bit
    task automatic t_ir;
        int w;
        int n;
        logic p;
        for (int lp = 0; lp < 2; lp++) begin
            wr_reg(UPC_OFS_CTRL, 32'h0000_0302 | (32'(lp) << UPC_INFRARED_LOW_POWER_SELECT_BIT));
            wr_reg(UPC_OFS_DATA, 32'h0000_0000);
            repeat (20) @(posedge ref_clk);
            wr_reg(UPC_OFS_CTRL, 32'h0000_0303 | (32'(lp) << UPC_INFRARED_LOW_POWER_SELECT_BIT));
            w = 0;
            n = 0;
            p = 1'b0;
            repeat (11 * BIT) begin
                @(negedge ref_clk);
                n += int'(tx && !p);
                w += int'(tx && n == 1);
                p = tx;
            end
            `CHK("pulse width", lp ? UPC_LP_TICKS * UPC_LP_REF_CYC : UPC_SIR_TICKS * BIT / UPC_OS, w)
            `CHK("pulse count", 9, n)
        end
    endtask
    // counts, verdict, end of run
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // hang guard at about twice the expected run
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 80000) begin
            mismatches++;
            complete_run();
        end
    end
    initial begin
        repeat (16) @(posedge ref_clk);
        resetn <= 1'b1;
        @(posedge ref_clk);
        t_regs();
        t_gate();
        t_abort();
        t_loop();
        t_rx();
        t_ir();
        complete_run();
    end
endmodule // upc_top_tb
`default_nettype wire
